// ===== src/apb_pkg.sv
// shared constants and types for the apdu block transport ends
package apb_pkg;
  // ==========================================================
  // block framing
  localparam int IFS_MAX = 32; // information_field bytes per I-block
  localparam logic [4:0] IFS_LAST = 5'(IFS_MAX - 1);
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 9; // byte plus apdu-last flag
  localparam int FIFO_SLACK = FIFO_DEPTH - 3; // ready drops while two words are still free
  // ==========================================================
  // apdu layout
  localparam logic [8:0] INS_POS = 9'h001; // byte index of the instruction
  localparam logic [8:0] CMD_HDR_MAX = 9'h005; // longer commands carry data
  localparam logic [8:0] LEN_SAT = 9'h1FF;
  localparam logic [7:0] CHAN_MASK = 8'h03; // logical channel bits of class byte
  localparam logic [7:0] INS_DELIVERY = 8'hC2; // toolkit_data_delivery instruction
  // ==========================================================
  // status words
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  localparam logic [7:0] SW1_WARN_A = 8'h62;
  localparam logic [7:0] SW1_WARN_B = 8'h63;
  localparam logic [3:0] SW1_APP_NIB = 4'h9;
  localparam logic [7:0] SW1_PEND = 8'h91;
  localparam logic [7:0] SW1_BUSY = 8'h93;
  localparam logic [7:0] SW2_BUSY = 8'h00;
  localparam logic [7:0] SW1_CHKERR = 8'h6F;
  // case code is {command data present, response data present}
  typedef enum logic [1:0] {
    APB_CASE1 = 2'h0,
    APB_CASE2 = 2'h1,
    APB_CASE3 = 2'h2,
    APB_CASE4 = 2'h3
  } apb_case_t;
  // warning, application and success classes may carry data
  function automatic logic apb_data_ok(input logic [7:0] sw1);
    apb_data_ok = (sw1 == SW1_WARN_A) || (sw1 == SW1_WARN_B) || (sw1[7:4] == SW1_APP_NIB);
  endfunction : apb_data_ok
endpackage : apb_pkg

// ===== src/apb_link_if.sv
// I-block byte link between terminal and card
`timescale 1ns/1ps
interface apb_link_if (
  input logic clk, // link clock
  input logic nrst // async reset, active low
);
  logic t2c_valid; // terminal to card byte valid
  logic [7:0] t2c_data; // information_field byte
  logic t2c_end; // last byte of this I-block
  logic t2c_chain; // with end: more blocks follow
  logic t2c_ready; // card takes the byte
  logic c2t_valid; // card to terminal byte valid
  logic [7:0] c2t_data;
  logic c2t_end;
  logic c2t_chain;
  logic c2t_ready; // terminal takes the byte
  modport term (
    output t2c_valid, t2c_data, t2c_end, t2c_chain, c2t_ready,
    input t2c_ready, c2t_valid, c2t_data, c2t_end, c2t_chain
  );
  modport card (
    input t2c_valid, t2c_data, t2c_end, t2c_chain, c2t_ready,
    output t2c_ready, c2t_valid, c2t_data, c2t_end, c2t_chain
  );
endinterface : apb_link_if

// ===== src/apb_card.sv
// card end: command reassembly fifo and response framing
`timescale 1ns/1ps
// ==========================================================
// fifo of command bytes
module apb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk, // clock
  input wire logic nrst, // async reset, active low
  input wire logic in_valid, // write request
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic in_ready, // not full
  output logic out_valid, // not empty
  output logic [WIDTH-1:0] out_data, // head word
  input wire logic out_ready, // reader takes head
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  // pointers wrap naturally, depth is a power of two
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? AW'(wp + 1'b1) : wp;
    next_rp = pop ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + (AW+1)'(push) - (AW+1)'(pop));
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
  // storage has no reset, contents are gated by cnt
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign level = cnt;
endmodule : apb_fifo

// ==========================================================
// card end
module apb_card
  import apb_pkg::*;
(
  input wire logic clk, // 200 MHz clock
  input wire logic nrst, // async reset, active low
  apb_link_if.card lnk, // link to terminal
  output logic cmd_valid, // command byte available
  output logic [7:0] cmd_data, // command byte
  output logic cmd_last, // last byte of the apdu
  input wire logic cmd_ready, // user takes command byte
  output logic cmd_done, // pulse: whole command received
  input wire logic rsp_go, // pulse: status ready
  input wire logic [7:0] rsp_sw1, // status byte 1
  input wire logic [7:0] rsp_sw2, // status byte 2
  input wire logic rsp_has_data, // response data follows
  input wire logic rsp_valid, // response byte valid
  input wire logic [7:0] rsp_data, // response byte
  input wire logic rsp_last, // last response byte
  output logic rsp_ready, // card takes response byte
  input wire logic toolkit_pending, // proactive command waiting
  input wire logic [7:0] pending_len, // its length
  input wire logic toolkit_busy, // card_toolkit_layer cannot take delivery
  output apb_case_t apdu_case, // case of finished pair
  output logic case_valid // pulse: apdu_case updated
);
  typedef enum logic [5:0] {
    C_RX = 6'b000001,
    C_WAIT = 6'b000010,
    C_DATA = 6'b000100,
    C_DROP = 6'b001000,
    C_SW1 = 6'b010000,
    C_SW2 = 6'b100000
  } apb_cstate_t;
  apb_cstate_t state, next_state;
  logic rx_ready, next_rx_ready;
  logic tx_valid, next_tx_valid, tx_end, next_tx_end, tx_chain, next_tx_chain;
  logic [7:0] tx_data, next_tx_data, ins, next_ins, sw1, next_sw1, sw2, next_sw2;
  logic [4:0] tx_cnt, next_tx_cnt;
  logic [8:0] len, next_len;
  logic sent, next_sent, rsp_rdy, next_rsp_rdy, done, next_done, cval, next_cval;
  apb_case_t next_case;
  logic take, tx_fire, busy, allow, fifo_in_ready, fifo_valid;
  logic [FIFO_WIDTH-1:0] fifo_out;
  logic [$clog2(FIFO_DEPTH):0] level;

  assign take = lnk.t2c_valid && rx_ready && fifo_in_ready;
  assign tx_fire = tx_valid && lnk.c2t_ready;

  // chained blocks land in order in one fifo, apdu ends at unchained end
  apb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(take),
    .in_data({lnk.t2c_end && !lnk.t2c_chain, lnk.t2c_data}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_out),
    .out_ready(cmd_ready),
    .level(level)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    next_state = state;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_end = tx_end;
    next_tx_chain = tx_chain;
    next_tx_cnt = tx_cnt;
    next_len = len;
    next_ins = ins;
    next_sw1 = sw1;
    next_sw2 = sw2;
    next_sent = sent;
    next_rsp_rdy = rsp_rdy;
    next_done = 1'b0;
    next_cval = 1'b0;
    next_case = apdu_case;
    busy = (ins == INS_DELIVERY) && toolkit_busy;
    allow = apb_data_ok(rsp_sw1) && !busy;
    // block counter restarts after each end byte leaves
    if (tx_fire) begin
      next_tx_valid = 1'b0;
      next_tx_cnt = tx_end ? 5'h00 : 5'(tx_cnt + 1'b1);
    end
    unique case (state)
      C_RX: begin
        if (take) begin
          next_len = (len == LEN_SAT) ? len : 9'(len + 1'b1);
          if (len == INS_POS) begin
            next_ins = lnk.t2c_data;
          end
          if (lnk.t2c_end && !lnk.t2c_chain) begin
            next_state = C_WAIT;
            next_done = 1'b1;
          end
        end
      end
      C_WAIT: begin
        if (rsp_go) begin
          next_sent = 1'b0;
          next_sw1 = rsp_sw1;
          next_sw2 = rsp_sw2;
          if (busy) begin
            next_sw1 = SW1_BUSY;
            next_sw2 = SW2_BUSY;
          end else if (rsp_sw1 == SW1_OK && rsp_sw2 == SW2_OK && toolkit_pending) begin
            next_sw1 = SW1_PEND;
            next_sw2 = pending_len;
          end
          next_rsp_rdy = rsp_has_data;
          if (!rsp_has_data) begin
            next_state = C_SW1;
          end else if (allow) begin
            next_state = C_DATA;
          end else begin
            next_state = C_DROP;
          end
        end
      end
      C_DATA: begin
        if (tx_fire) begin
          next_rsp_rdy = 1'b1;
        end
        // one byte in flight at a time, so rsp_ready stays a plain flop
        if (rsp_valid && rsp_rdy) begin
          next_tx_valid = 1'b1;
          next_tx_data = rsp_data;
          next_tx_end = (tx_cnt == IFS_LAST);
          next_tx_chain = 1'b1;
          next_sent = 1'b1;
          next_rsp_rdy = 1'b0;
          if (rsp_last) begin
            next_state = C_SW1;
          end
        end
      end
      C_DROP: begin
        // data of a failing status is swallowed, never sent
        if (rsp_valid && rsp_last) begin
          next_rsp_rdy = 1'b0;
          next_state = C_SW1;
        end
      end
      C_SW1: begin
        if (!tx_valid) begin
          next_tx_valid = 1'b1;
          next_tx_data = sw1;
          next_tx_end = (tx_cnt == IFS_LAST);
          next_tx_chain = 1'b1;
          next_state = C_SW2;
        end
      end
      C_SW2: begin
        if (!tx_valid) begin
          next_tx_valid = 1'b1;
          next_tx_data = sw2;
          next_tx_end = 1'b1;
          next_tx_chain = 1'b0;
          next_len = '0;
          next_cval = 1'b1;
          next_case = apb_case_t'({len > CMD_HDR_MAX, sent});
          next_state = C_RX;
        end
      end
    endcase
    // early drop leaves room for bytes already in flight
    next_rx_ready = (next_state == C_RX) && (level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_SLACK));
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= C_RX;
      rx_ready <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_end <= 1'b0;
      tx_chain <= 1'b0;
      tx_cnt <= 5'h00;
      len <= 9'h000;
      ins <= 8'h00;
      sw1 <= 8'h00;
      sw2 <= 8'h00;
      sent <= 1'b0;
      rsp_rdy <= 1'b0;
      done <= 1'b0;
      cval <= 1'b0;
      apdu_case <= APB_CASE1;
    end else begin
      state <= next_state;
      rx_ready <= next_rx_ready;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_end <= next_tx_end;
      tx_chain <= next_tx_chain;
      tx_cnt <= next_tx_cnt;
      len <= next_len;
      ins <= next_ins;
      sw1 <= next_sw1;
      sw2 <= next_sw2;
      sent <= next_sent;
      rsp_rdy <= next_rsp_rdy;
      done <= next_done;
      cval <= next_cval;
      apdu_case <= next_case;
    end
  end

  assign lnk.t2c_ready = rx_ready;
  assign lnk.c2t_valid = tx_valid;
  assign lnk.c2t_data = tx_data;
  assign lnk.c2t_end = tx_end;
  assign lnk.c2t_chain = tx_chain;
  assign cmd_valid = fifo_valid;
  assign cmd_data = fifo_out[7:0];
  assign cmd_last = fifo_out[8];
  assign cmd_done = done;
  assign rsp_ready = rsp_rdy;
  assign case_valid = cval;
endmodule : apb_card

// ===== src/apb_term.sv
// terminal end: command splitting, response rebuild, toolkit status handling
`timescale 1ns/1ps
module apb_term
  import apb_pkg::*;
(
  input wire logic clk, // 200 MHz clock
  input wire logic nrst, // async reset, active low
  apb_link_if.term lnk, // link to card
  input wire logic cmd_valid, // command byte valid
  input wire logic [7:0] cmd_data, // command byte
  input wire logic cmd_last, // last byte of the apdu
  input wire logic cmd_toolkit, // apdu is a fetch or result report
  output logic cmd_ready, // terminal takes command byte
  output logic rsp_valid, // pulse: response data byte
  output logic [7:0] rsp_data, // response data byte
  output logic rsp_done, // pulse: response complete
  output logic [7:0] rsp_sw1, // status byte 1
  output logic [7:0] rsp_sw2, // status byte 2
  output apb_case_t apdu_case, // case of finished pair
  output logic fetch_pending, // proactive command waits
  output logic [7:0] pending_len, // its length
  output logic ack_pos, // pulse: normal acknowledgement channel
  output logic ack_neg // pulse: error acknowledgement channel
);
  typedef enum logic [1:0] {
    T_TX = 2'b01,
    T_RX = 2'b10
  } apb_tstate_t;
  apb_tstate_t state, next_state;
  logic tx_valid, next_tx_valid, tx_end, next_tx_end, tx_chain, next_tx_chain;
  logic [7:0] tx_data, next_tx_data, ins, next_ins;
  logic [4:0] tx_cnt, next_tx_cnt;
  logic [8:0] idx, next_idx;
  logic rdy, next_rdy, rx_ready, next_rx_ready;
  logic [7:0] h_old, next_h_old, h_new, next_h_new;
  logic [1:0] held, next_held;
  logic got, next_got, data_now, sw_ok, sw_warn;
  logic next_rsp_valid, next_rsp_done, next_ack_pos, next_ack_neg, next_pend;
  logic [7:0] next_rsp_data, next_sw1, next_sw2, next_plen;
  apb_case_t next_case;
  logic take, tx_fire, load, final_blk;

  assign take = lnk.c2t_valid && rx_ready;
  assign tx_fire = tx_valid && lnk.t2c_ready;
  assign load = cmd_valid && rdy;
  assign final_blk = lnk.c2t_end && !lnk.c2t_chain;

  // ==========================================================
  // next-state logic
  always_comb begin
    next_state = state;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_end = tx_end;
    next_tx_chain = tx_chain;
    next_tx_cnt = tx_cnt;
    next_idx = idx;
    next_ins = ins;
    next_h_old = h_old;
    next_h_new = h_new;
    next_held = held;
    next_got = got;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_rsp_done = 1'b0;
    next_sw1 = rsp_sw1;
    next_sw2 = rsp_sw2;
    next_case = apdu_case;
    next_pend = fetch_pending;
    next_plen = pending_len;
    next_ack_pos = 1'b0;
    next_ack_neg = 1'b0;
    data_now = got || (held == 2'h2);
    sw_ok = (h_new == SW1_OK) && (lnk.c2t_data == SW2_OK);
    sw_warn = (h_new == SW1_WARN_A) || (h_new == SW1_WARN_B);
    if (tx_fire) begin
      next_tx_valid = 1'b0;
      next_tx_cnt = tx_end ? 5'h00 : 5'(tx_cnt + 1'b1);
    end
    unique case (state)
      T_TX: begin
        // one byte in flight, so cmd_ready is a plain flop
        if (load) begin
          next_tx_valid = 1'b1;
          next_tx_data = cmd_data;
          if (idx == '0 && cmd_toolkit) begin
            next_tx_data = cmd_data & ~CHAN_MASK;
            next_pend = 1'b0;
          end
          if (idx == INS_POS) begin
            next_ins = cmd_data;
          end
          next_idx = (idx == LEN_SAT) ? idx : 9'(idx + 1'b1);
          // block closes when full or at the apdu's last byte
          next_tx_end = cmd_last || (tx_cnt == IFS_LAST);
          next_tx_chain = !cmd_last;
          if (cmd_last) begin
            next_state = T_RX;
            next_held = 2'h0;
            next_got = 1'b0;
          end
        end
      end
      T_RX: begin
        if (take) begin
          // two-byte lag keeps the trailing status out of the data
          if (held == 2'h2) begin
            next_rsp_valid = 1'b1;
            next_rsp_data = h_old;
            next_got = 1'b1;
          end
          next_h_old = h_new;
          next_h_new = lnk.c2t_data;
          next_held = (held == 2'h2) ? held : 2'(held + 1'b1);
          if (final_blk) begin
            next_sw1 = h_new;
            next_sw2 = lnk.c2t_data;
            next_rsp_done = 1'b1;
            next_case = apb_case_t'({idx > CMD_HDR_MAX, data_now});
            if (h_new == SW1_PEND) begin
              next_pend = 1'b1;
              next_plen = lnk.c2t_data;
            end
            if (ins == INS_DELIVERY) begin
              next_ack_neg = (h_new == SW1_CHKERR) || (data_now && sw_warn);
              next_ack_pos = data_now && sw_ok;
            end
            next_idx = '0;
            next_state = T_TX;
          end
        end
      end
    endcase
    next_rdy = (next_state == T_TX) && !next_tx_valid;
    next_rx_ready = (next_state == T_RX);
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= T_TX;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_end <= 1'b0;
      tx_chain <= 1'b0;
      tx_cnt <= 5'h00;
      idx <= 9'h000;
      ins <= 8'h00;
      rdy <= 1'b0;
      rx_ready <= 1'b0;
      h_old <= 8'h00;
      h_new <= 8'h00;
      held <= 2'h0;
      got <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_done <= 1'b0;
      rsp_sw1 <= 8'h00;
      rsp_sw2 <= 8'h00;
      apdu_case <= APB_CASE1;
      fetch_pending <= 1'b0;
      pending_len <= 8'h00;
      ack_pos <= 1'b0;
      ack_neg <= 1'b0;
    end else begin
      state <= next_state;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_end <= next_tx_end;
      tx_chain <= next_tx_chain;
      tx_cnt <= next_tx_cnt;
      idx <= next_idx;
      ins <= next_ins;
      rdy <= next_rdy;
      rx_ready <= next_rx_ready;
      h_old <= next_h_old;
      h_new <= next_h_new;
      held <= next_held;
      got <= next_got;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_done <= next_rsp_done;
      rsp_sw1 <= next_sw1;
      rsp_sw2 <= next_sw2;
      apdu_case <= next_case;
      fetch_pending <= next_pend;
      pending_len <= next_plen;
      ack_pos <= next_ack_pos;
      ack_neg <= next_ack_neg;
    end
  end

  // link drive straight from flops
  assign lnk.t2c_valid = tx_valid;
  assign lnk.t2c_data = tx_data;
  assign lnk.t2c_end = tx_end;
  assign lnk.t2c_chain = tx_chain;
  assign lnk.c2t_ready = rx_ready;
  assign cmd_ready = rdy;
endmodule : apb_term

// ===== tb/apb_link_asserts.sv
// link checker for the apdu block transport ends
`timescale 1ns/1ps
module apb_link_asserts (
  input wire logic clk, // clock
  input wire logic nrst, // async reset, active low
  input wire logic t2c_valid, // terminal byte valid
  input wire logic [7:0] t2c_data, // terminal byte
  input wire logic t2c_end, // terminal block end
  input wire logic t2c_chain, // terminal more blocks
  input wire logic t2c_ready, // card takes byte
  input wire logic c2t_valid, // card byte valid
  input wire logic [7:0] c2t_data, // card byte
  input wire logic c2t_end, // card block end
  input wire logic c2t_chain, // card more blocks
  input wire logic c2t_ready // terminal takes byte
);
  // ==========================================================
  // helper state: bytes per block, pair in progress
  logic [4:0] t_cnt;
  logic [4:0] next_t_cnt;
  logic [4:0] c_cnt;
  logic [4:0] next_c_cnt;
  logic await_rsp;
  logic next_await_rsp;
  wire t_take = t2c_valid && t2c_ready;
  wire c_take = c2t_valid && c2t_ready;
  // counts restart at every block end, whatever the chain bit
  always_comb begin
    next_t_cnt = t_cnt;
    next_c_cnt = c_cnt;
    next_await_rsp = await_rsp;
    if (t_take) next_t_cnt = t2c_end ? 5'h00 : t_cnt + 5'h01;
    if (c_take) next_c_cnt = c2t_end ? 5'h00 : c_cnt + 5'h01;
    if (t_take && t2c_end && !t2c_chain) next_await_rsp = 1'b1;
    if (c_take && c2t_end && !c2t_chain) next_await_rsp = 1'b0;
  end
  // registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t_cnt <= 5'h00;
      c_cnt <= 5'h00;
      await_rsp <= 1'b0;
    end else begin
      t_cnt <= next_t_cnt;
      c_cnt <= next_c_cnt;
      await_rsp <= next_await_rsp;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // assertions
  AST_T2C_HOLD: assert property (t2c_valid && !t2c_ready |=>
    t2c_valid && $stable({t2c_data, t2c_end, t2c_chain})) else $error("terminal byte not held");
  AST_C2T_HOLD: assert property (c2t_valid && !c2t_ready |=>
    c2t_valid && $stable({c2t_data, c2t_end, c2t_chain})) else $error("card byte not held");
  AST_T2C_GAP: assert property (t_take |=> !t2c_valid) else $error("terminal byte reused");
  AST_C2T_GAP: assert property (c_take |=> !c2t_valid) else $error("card byte reused");
  AST_T2C_BLOCK: assert property (t_take && t_cnt == 5'h1F |-> t2c_end)
    else $error("command block too long");
  AST_C2T_BLOCK: assert property (c_take && c_cnt == 5'h1F |-> c2t_end)
    else $error("response block too long");
  AST_ONE_RSP: assert property (c2t_valid |-> await_rsp) else $error("response without command");
  AST_NO_NEW_CMD: assert property (t2c_valid |-> !await_rsp) else $error("command before response");
  // main scenarios
  cover property (t_take && t2c_end && t2c_chain);
  cover property (c_take && c2t_end && c2t_chain);
  cover property (t2c_valid && !t2c_ready);
endmodule : apb_link_asserts

// ===== tb/apdu_block_transport_toolkit_status_tb.sv
// bench: terminal and card ends joined over the link
`timescale 1ns/1ps
module apdu_block_transport_toolkit_status_tb;
  import apb_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic t_cmd_valid = 1'b0, t_cmd_last = 1'b0, t_cmd_tk = 1'b0;
  logic [7:0] t_cmd_data = 8'h00;
  logic t_cmd_ready, t_rsp_valid, t_rsp_done, t_fp, t_apos, t_aneg;
  logic [7:0] t_rsp_data, t_sw1, t_sw2, t_plen;
  apb_case_t t_case, c_case;
  logic c_cmd_valid, c_cmd_last, c_done, c_rr, c_cv;
  logic [7:0] c_cmd_data;
  logic c_cmd_ready = 1'b0, c_go = 1'b0, c_hd = 1'b0, c_rv = 1'b0, c_rl = 1'b0;
  logic c_tp = 1'b0, c_tb = 1'b0, stall = 1'b0;
  logic [7:0] c_sw1 = 8'h00, c_sw2 = 8'h00, c_rd = 8'h00, c_plen = 8'h00;
  logic [7:0] cq[$];
  logic [7:0] tq[$];
  logic cdone, tdone, tpos, tneg, exp_fp = 1'b0;
  int n_errors = 0, check_count = 0, cyc = 0, clast = 0, cvn = 0;
  // 200 MHz
  initial forever #2.5 clk = ~clk;
  apb_link_if i_apb_link_if (.clk(clk), .nrst(nrst));
  apb_term i_apb_term (.clk(clk), .nrst(nrst), .lnk(i_apb_link_if), .cmd_valid(t_cmd_valid),
    .cmd_data(t_cmd_data), .cmd_last(t_cmd_last), .cmd_toolkit(t_cmd_tk), .cmd_ready(t_cmd_ready),
    .rsp_valid(t_rsp_valid), .rsp_data(t_rsp_data), .rsp_done(t_rsp_done), .rsp_sw1(t_sw1),
    .rsp_sw2(t_sw2), .apdu_case(t_case), .fetch_pending(t_fp), .pending_len(t_plen),
    .ack_pos(t_apos), .ack_neg(t_aneg));
  apb_card i_apb_card (.clk(clk), .nrst(nrst), .lnk(i_apb_link_if), .cmd_valid(c_cmd_valid),
    .cmd_data(c_cmd_data), .cmd_last(c_cmd_last), .cmd_ready(c_cmd_ready), .cmd_done(c_done),
    .rsp_go(c_go), .rsp_sw1(c_sw1), .rsp_sw2(c_sw2), .rsp_has_data(c_hd), .rsp_valid(c_rv),
    .rsp_data(c_rd), .rsp_last(c_rl), .rsp_ready(c_rr), .toolkit_pending(c_tp),
    .pending_len(c_plen), .toolkit_busy(c_tb), .apdu_case(c_case), .case_valid(c_cv));
  apb_link_asserts i_apb_link_asserts (.clk(clk), .nrst(nrst),
    .t2c_valid(i_apb_link_if.t2c_valid), .t2c_data(i_apb_link_if.t2c_data),
    .t2c_end(i_apb_link_if.t2c_end), .t2c_chain(i_apb_link_if.t2c_chain),
    .t2c_ready(i_apb_link_if.t2c_ready), .c2t_valid(i_apb_link_if.c2t_valid),
    .c2t_data(i_apb_link_if.c2t_data), .c2t_end(i_apb_link_if.c2t_end),
    .c2t_chain(i_apb_link_if.c2t_chain), .c2t_ready(i_apb_link_if.c2t_ready));
  // card user takes every other cycle, none while stalled, so the fifo fills
  always @(negedge clk) c_cmd_ready <= !stall && !c_cmd_ready;
  // ==========================================================
  // monitors and hang limit
  always @(posedge clk) begin
    if (c_cmd_valid && c_cmd_ready && c_cmd_last) clast = cq.size();
    if (c_cmd_valid && c_cmd_ready) cq.push_back(c_cmd_data);
    if (c_cv) cvn++;
    if (c_done) cdone = 1'b1;
    if (t_rsp_valid) tq.push_back(t_rsp_data);
    if (t_rsp_done) begin
      tdone = 1'b1;
      tpos = t_apos;
      tneg = t_aneg;
    end
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] cb(input logic [7:0] cla, ins, input int k);
    return k == 0 ? cla : k == 1 ? ins : 8'(k) ^ 8'h5A;
  endfunction : cb
  // ==========================================================
  // one command-response pair with its expectations
  task automatic xfer(input logic [7:0] cla, ins, input int n, input logic tk,
    input logic [7:0] s1, s2, input int nd, input logic [7:0] pend, input logic busy);
    logic [7:0] e1, e2;
    logic dok, dlv, ok, warn;
    int k;
    cq.delete();
    tq.delete();
    cdone = 1'b0;
    tdone = 1'b0;
    clast = -1;
    cvn = 0;
    c_tp = pend != 8'h00;
    c_plen = pend;
    c_tb = busy;
    t_cmd_tk = tk;
    fork
      begin
        @(negedge clk);
        for (k = 0; k < n; k++) begin
          t_cmd_valid = 1'b1;
          t_cmd_data = cb(cla, ins, k);
          t_cmd_last = k == n - 1;
          do @(posedge clk); while (t_cmd_ready !== 1'b1);
          @(negedge clk);
        end
        t_cmd_valid = 1'b0;
      end
      begin
        stall = n > 64;
        repeat (300) @(negedge clk);
        stall = 1'b0;
      end
    join
    // card user drains the whole command before answering, hangs hit the cycle limit
    while (!cdone || c_cmd_valid) @(posedge clk);
    @(negedge clk);
    c_go = 1'b1;
    c_sw1 = s1;
    c_sw2 = s2;
    c_hd = nd != 0;
    @(negedge clk);
    c_go = 1'b0;
    for (k = 0; k < nd; k++) begin
      c_rv = 1'b1;
      c_rd = 8'(k) ^ 8'hC3;
      c_rl = k == nd - 1;
      do @(posedge clk); while (c_rr !== 1'b1);
      @(negedge clk);
    end
    c_rv = 1'b0;
    while (!tdone) @(posedge clk);
    @(negedge clk);
    dlv = ins == INS_DELIVERY;
    ok = s1 == SW1_OK && s2 == SW2_OK;
    warn = s1 == SW1_WARN_A || s1 == SW1_WARN_B;
    dok = !(dlv && busy) && nd != 0 && (warn || s1[7:4] == SW1_APP_NIB);
    e1 = (dlv && busy) ? SW1_BUSY : (ok && pend != 8'h00) ? SW1_PEND : s1;
    e2 = (dlv && busy) ? SW2_BUSY : (ok && pend != 8'h00) ? pend : s2;
    if (pend != 8'h00) exp_fp = 1'b1;
    else if (tk) exp_fp = 1'b0;
    chk("command length", 16'(n), 16'(cq.size()));
    for (k = 0; k < cq.size(); k++)
      chk("command byte", (k == 0 && tk) ? cla & ~CHAN_MASK : cb(cla, ins, k), cq[k]);
    chk("response length", dok ? 16'(nd) : 16'h0000, 16'(tq.size()));
    for (k = 0; k < tq.size(); k++) chk("response byte", 8'(k) ^ 8'hC3, tq[k]);
    chk("status word", {e1, e2}, {t_sw1, t_sw2});
    chk("terminal case", {n > 5, dok}, t_case);
    chk("card case", {n > 5, dok}, c_case);
    chk("acks", {dlv && !busy && ok && dok, dlv && !busy && (s1 == SW1_CHKERR || (dok && warn))},
      {tpos, tneg});
    chk("fetch pending", exp_fp, t_fp);
    chk("command last", 16'(n - 1), 16'(clast));
    chk("case pulses", 16'h0001, 16'(cvn));
    if (pend != 8'h00) chk("pending length", pend, t_plen);
  endtask : xfer
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    xfer(8'h80, 8'h10, 4, 1'b0, 8'h90, 8'h00, 0, 8'h00, 1'b0);
    xfer(8'h00, 8'hB0, 5, 1'b0, 8'h90, 8'h00, 40, 8'h00, 1'b0);
    xfer(8'h02, 8'hD6, 70, 1'b0, 8'h6A, 8'h82, 3, 8'h00, 1'b0);
    xfer(8'h01, 8'h88, 40, 1'b0, 8'h90, 8'h00, 31, 8'h1E, 1'b0);
    xfer(8'h03, 8'h12, 5, 1'b1, 8'h90, 8'h00, 8, 8'h00, 1'b0);
    xfer(8'h82, 8'h14, 12, 1'b1, 8'h90, 8'h00, 0, 8'h00, 1'b0);
    xfer(8'h80, 8'hC2, 10, 1'b0, 8'h6F, 8'h00, 0, 8'h00, 1'b0);
    xfer(8'h80, 8'hC2, 10, 1'b0, 8'h90, 8'h00, 6, 8'h00, 1'b0);
    xfer(8'h80, 8'hC2, 10, 1'b0, 8'h63, 8'hC1, 6, 8'h00, 1'b0);
    xfer(8'h80, 8'hC2, 10, 1'b0, 8'h90, 8'h00, 6, 8'h00, 1'b1);
    xfer(8'h00, 8'hCA, 5, 1'b0, 8'h62, 8'h83, 4, 8'h00, 1'b0);
    complete_run();
  end
endmodule : apdu_block_transport_toolkit_status_tb
